// ==== rtl/dma_channel_transfer_control.sv ====
// Transfer-control word of one DMA channel: address stepping, item widths,
// burst lengths and the channel interrupt mask, behind an APB slave.
// Assumes transfer strobes and raw interrupt events come from channel logic on pclk.
//
// Overview of operation
// - Source address increments on 00, decrements on 01, holds on 1x; resets to 00.
// - Destination address increments on 00, decrements on 01, holds on 1x; resets 00.
// - Width codes map 000..100 to 8..128 bits, 101 and 11x to 256; reset 000.
// - The source read drives AHB hsize from the source item width.
// - Interrupt enable masks all channel interrupts; raw status still sets; resets to one.
// - Burst codes 000..111 give 1, 4, 8, 16, 32, 64, 128, 256 items.
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ns
module dma_channel_transfer_control
  import dma_ctl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic src_xfer_done,
  input wire logic dst_xfer_done,
  input wire logic [IRQ_NUM-1:0] irq_event,
  output logic [31:0] src_addr,
  output logic [31:0] dst_addr,
  output logic [2:0] hsize_read,
  output logic [2:0] src_item_width,
  output logic [2:0] dst_item_width,
  output logic [8:0] src_burst_items,
  output logic [8:0] dst_burst_items,
  output logic [IRQ_NUM-1:0] chan_irq
);

  // Control fields
  logic chan_irq_mask_en;
  logic [1:0] src_addr_step;
  logic [1:0] dst_addr_step;
  logic [2:0] src_burst_len;
  logic [2:0] dst_burst_len;
  logic [2:0] src_width_field;
  logic [2:0] dst_width_field;
  logic [31:0] src_start;
  logic [31:0] dst_start;
  logic [IRQ_NUM-1:0] raw_irq;
  logic [IRQ_NUM-1:0] next_raw_irq;

  // Bus decode
  logic wr_fire;
  logic setup;
  logic hit;
  logic [31:0] next_prdata;
  logic load_src;
  logic load_dst;
  logic [31:0] src_now;
  logic [31:0] dst_now;
  logic [31:0] ctl_word;
  logic [31:0] status_word;
  logic src_width_bad;
  logic dst_width_bad;

  assign setup = psel && !penable;
  assign wr_fire = psel && penable && pready && pwrite;

  always_comb begin
    unique case (paddr)
      OFFS_CTL_LOW, OFFS_SRC_START, OFFS_DST_START, OFFS_SRC_NOW,
      OFFS_DST_NOW, OFFS_RAW_IRQ, OFFS_CFG_STATUS: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // Zero wait states: pready rises one cycle after setup and holds for the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  // Unmapped addresses answer with an error and leave every register untouched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup && !hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  always_comb begin
    ctl_word = 32'h0000_0000;
    ctl_word[POS_IRQ_EN] = chan_irq_mask_en;
    ctl_word[POS_DST_WIDTH +: 3] = dst_width_field;
    ctl_word[POS_SRC_WIDTH +: 3] = src_width_field;
    ctl_word[POS_DST_STEP +: 2] = dst_addr_step;
    ctl_word[POS_SRC_STEP +: 2] = src_addr_step;
    ctl_word[POS_DST_BURST +: 3] = dst_burst_len;
    ctl_word[POS_SRC_BURST +: 3] = src_burst_len;
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[POS_SRC_WIDTH_BAD] = src_width_bad;
    status_word[POS_DST_WIDTH_BAD] = dst_width_bad;
  end

  always_comb begin
    unique case (paddr)
      OFFS_CTL_LOW: next_prdata = ctl_word;
      OFFS_SRC_START: next_prdata = src_start;
      OFFS_DST_START: next_prdata = dst_start;
      OFFS_SRC_NOW: next_prdata = src_now;
      OFFS_DST_NOW: next_prdata = dst_now;
      OFFS_RAW_IRQ: next_prdata = {{(32-IRQ_NUM){1'b0}}, raw_irq};
      OFFS_CFG_STATUS: next_prdata = status_word;
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  // Control word fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_irq_mask_en <= RST_IRQ_EN;
    end else if (wr_fire && paddr == OFFS_CTL_LOW) begin
      chan_irq_mask_en <= pwdata[POS_IRQ_EN];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_addr_step <= RST_STEP;
      dst_addr_step <= RST_STEP;
    end else if (wr_fire && paddr == OFFS_CTL_LOW) begin
      src_addr_step <= pwdata[POS_SRC_STEP +: 2];
      dst_addr_step <= pwdata[POS_DST_STEP +: 2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_width_field <= RST_WIDTH;
      dst_width_field <= RST_WIDTH;
    end else if (wr_fire && paddr == OFFS_CTL_LOW) begin
      src_width_field <= pwdata[POS_SRC_WIDTH +: 3];
      dst_width_field <= pwdata[POS_DST_WIDTH +: 3];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_burst_len <= RST_BURST;
      dst_burst_len <= RST_BURST;
    end else if (wr_fire && paddr == OFFS_CTL_LOW) begin
      src_burst_len <= pwdata[POS_SRC_BURST +: 3];
      dst_burst_len <= pwdata[POS_DST_BURST +: 3];
    end
  end

  // Start addresses; a write also reloads the running address of that side
  assign load_src = wr_fire && paddr == OFFS_SRC_START;
  assign load_dst = wr_fire && paddr == OFFS_DST_START;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_start <= 32'h0000_0000;
    end else if (load_src) begin
      src_start <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dst_start <= 32'h0000_0000;
    end else if (load_dst) begin
      dst_start <= pwdata;
    end
  end

  addr_stepper src_side (
    .pclk(pclk),
    .presetn(presetn),
    .load(load_src),
    .load_addr(pwdata),
    .step(src_xfer_done),
    .step_code(src_addr_step),
    .width_code(src_width_field),
    .addr(src_now)
  );

  addr_stepper dst_side (
    .pclk(pclk),
    .presetn(presetn),
    .load(load_dst),
    .load_addr(pwdata),
    .step(dst_xfer_done),
    .step_code(dst_addr_step),
    .width_code(dst_width_field),
    .addr(dst_now)
  );

  // Registered copies so every output leaves from a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_addr <= 32'h0000_0000;
    end else begin
      src_addr <= src_now;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dst_addr <= 32'h0000_0000;
    end else begin
      dst_addr <= dst_now;
    end
  end

  // Codes 110 and 111 have no 256-bit meaning on AHB, so they fold onto 101
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hsize_read <= RST_WIDTH;
    end else begin
      hsize_read <= (src_width_field > WIDTH_CODE_256) ? WIDTH_CODE_256 : src_width_field;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_item_width <= RST_WIDTH;
      dst_item_width <= RST_WIDTH;
    end else begin
      src_item_width <= (src_width_field > WIDTH_CODE_256) ? WIDTH_CODE_256 : src_width_field;
      dst_item_width <= (dst_width_field > WIDTH_CODE_256) ? WIDTH_CODE_256 : dst_width_field;
    end
  end

  // Widths above 32 bits are flagged but still honoured; the channel does not refuse them
  assign src_width_bad = src_width_field > WIDTH_CODE_32;
  assign dst_width_bad = dst_width_field > WIDTH_CODE_32;

  // Burst item counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_burst_items <= 9'(9'h002 << RST_BURST);
    end else begin
      src_burst_items <= (src_burst_len == BURST_CODE_SINGLE) ? BURST_ITEMS_SINGLE :
        9'(9'h002 << src_burst_len);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dst_burst_items <= 9'(9'h002 << RST_BURST);
    end else begin
      dst_burst_items <= (dst_burst_len == BURST_CODE_SINGLE) ? BURST_ITEMS_SINGLE :
        9'(9'h002 << dst_burst_len);
    end
  end

  // Raw status: write one to clear; an event in the clearing cycle stays set
  genvar i;
  generate
    for (i = 0; i < IRQ_NUM; i++) begin : g_raw
      always_comb begin
        next_raw_irq[i] = raw_irq[i];
        if (wr_fire && paddr == OFFS_RAW_IRQ && pwdata[i]) begin
          next_raw_irq[i] = 1'b0;
        end
        if (irq_event[i]) begin
          next_raw_irq[i] = 1'b1;
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_irq <= '0;
    end else begin
      raw_irq <= next_raw_irq;
    end
  end

  // One enable gates every channel interrupt output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_irq <= '0;
    end else begin
      chan_irq <= next_raw_irq & {IRQ_NUM{chan_irq_mask_en}};
    end
  end

endmodule

// ==== shared/dma_ctl_pkg.sv ====
// Constants shared by the channel transfer-control block and its address stepper.
// Assumes an APB slave with a 12-bit byte address and 32-bit data.
package dma_ctl_pkg;

  // Register byte offsets
  localparam logic [11:0] OFFS_CTL_LOW = 12'h018;
  localparam logic [11:0] OFFS_SRC_START = 12'h100;
  localparam logic [11:0] OFFS_DST_START = 12'h104;
  localparam logic [11:0] OFFS_SRC_NOW = 12'h108;
  localparam logic [11:0] OFFS_DST_NOW = 12'h10C;
  localparam logic [11:0] OFFS_RAW_IRQ = 12'h110;
  localparam logic [11:0] OFFS_CFG_STATUS = 12'h114;

  // Field positions in channel_transfer_control_low
  localparam int POS_IRQ_EN = 0;
  localparam int POS_DST_WIDTH = 1;
  localparam int POS_SRC_WIDTH = 4;
  localparam int POS_DST_STEP = 7;
  localparam int POS_SRC_STEP = 9;
  localparam int POS_DST_BURST = 11;
  localparam int POS_SRC_BURST = 14;

  // Field reset values
  localparam logic RST_IRQ_EN = 1'b1;
  localparam logic [2:0] RST_WIDTH = 3'h0;
  localparam logic [1:0] RST_STEP = 2'h0;
  localparam logic [2:0] RST_BURST = 3'h1;

  // Field positions in the configuration status register
  localparam int POS_SRC_WIDTH_BAD = 0;
  localparam int POS_DST_WIDTH_BAD = 1;

  // Raw interrupt sources of the channel
  localparam int IRQ_NUM = 5;

  // Item width codes and their byte counts
  localparam logic [2:0] WIDTH_CODE_8 = 3'h0;
  localparam logic [2:0] WIDTH_CODE_16 = 3'h1;
  localparam logic [2:0] WIDTH_CODE_32 = 3'h2;
  localparam logic [2:0] WIDTH_CODE_64 = 3'h3;
  localparam logic [2:0] WIDTH_CODE_128 = 3'h4;
  localparam logic [2:0] WIDTH_CODE_256 = 3'h5;
  localparam logic [5:0] BYTES_8 = 6'h01;
  localparam logic [5:0] BYTES_16 = 6'h02;
  localparam logic [5:0] BYTES_32 = 6'h04;
  localparam logic [5:0] BYTES_64 = 6'h08;
  localparam logic [5:0] BYTES_128 = 6'h10;
  localparam logic [5:0] BYTES_256 = 6'h20;

  // Burst-length codes: 000 is one item, code n above zero is 2^(n+1) items
  localparam logic [2:0] BURST_CODE_SINGLE = 3'h0;
  localparam logic [8:0] BURST_ITEMS_SINGLE = 9'h001;

  typedef enum logic [1:0] {
    STEP_INC = 2'b00,
    STEP_DEC = 2'b01,
    STEP_HOLD_LO = 2'b10,
    STEP_HOLD_HI = 2'b11
  } step_mode_type;

endpackage

// ==== rtl/addr_stepper.sv ====
// Address register of one side of a DMA channel, stepped once per transfer.
// Assumes load and step are single-cycle strobes from logic on pclk.
`timescale 1ns/1ns
module addr_stepper
  import dma_ctl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [31:0] load_addr,
  input wire logic step,
  input wire logic [1:0] step_code,
  input wire logic [2:0] width_code,
  output logic [31:0] addr
);

  logic [5:0] item_bytes;
  step_mode_type mode;

  assign mode = step_mode_type'(step_code);

  always_comb begin
    unique case (width_code)
      WIDTH_CODE_8: item_bytes = BYTES_8;
      WIDTH_CODE_16: item_bytes = BYTES_16;
      WIDTH_CODE_32: item_bytes = BYTES_32;
      WIDTH_CODE_64: item_bytes = BYTES_64;
      WIDTH_CODE_128: item_bytes = BYTES_128;
      default: item_bytes = BYTES_256;
    endcase
  end

  // A reload in the same cycle as a transfer wins; software restarts the side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr <= 32'h0000_0000;
    end else if (load) begin
      addr <= load_addr;
    end else if (step) begin
      unique case (mode)
        STEP_INC: addr <= addr + {26'h000_0000, item_bytes};
        STEP_DEC: addr <= addr - {26'h000_0000, item_bytes};
        STEP_HOLD_LO, STEP_HOLD_HI: addr <= addr;
      endcase
    end
  end

endmodule

// ==== bench/dma_ctl_monitor.sv ====
// Port-level assertions for the channel transfer-control block.
// Assumes the zero-wait APB slave and the register map of dma_ctl_pkg.
`timescale 1ns/1ns
module dma_ctl_monitor
  import dma_ctl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic src_xfer_done,
  input wire logic dst_xfer_done,
  input wire logic [IRQ_NUM-1:0] irq_event,
  input wire logic [31:0] src_addr,
  input wire logic [31:0] dst_addr,
  input wire logic [2:0] hsize_read,
  input wire logic [2:0] src_item_width,
  input wire logic [2:0] dst_item_width,
  input wire logic [8:0] src_burst_items,
  input wire logic [8:0] dst_burst_items,
  input wire logic [IRQ_NUM-1:0] chan_irq
);
  logic [31:0] ctl;
  logic wr;
  assign wr = psel && penable && pready && pwrite;
  // Shadow of the control word, so no design internals are needed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl <= 32'h0000_4801;
    end else if (wr && paddr == OFFS_CTL_LOW) begin
      ctl <= pwdata;
    end
  end
  function automatic logic [2:0] fold(input logic [2:0] c);
    return (c > 3'h5) ? 3'h5 : c;
  endfunction
  function automatic logic [31:0] delta(input logic [1:0] s, input logic [2:0] w);
    return s[1] ? 32'h0 : (s[0] ? -(32'h1 << fold(w)) : 32'h1 << fold(w));
  endfunction
  function automatic logic [8:0] items(input logic [2:0] c);
    return (c == 3'h0) ? 9'h001 : 9'h002 << c;
  endfunction
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_phase;
    psel && !penable;
  endsequence
  // Outputs lag a control write by one edge, so skip that window
  sequence quiet_ctl;
    !wr ##1 !wr;
  endsequence
  chk_src_step: assert property (
    src_xfer_done && !(wr && paddr == OFFS_SRC_START) |=> ##1
      src_addr == $past(src_addr) + $past(delta(ctl[10:9], ctl[6:4]), 2))
    else $error("source address stepped wrongly");
  chk_dst_step: assert property (
    dst_xfer_done && !(wr && paddr == OFFS_DST_START) |=> ##1
      dst_addr == $past(dst_addr) + $past(delta(ctl[8:7], ctl[3:1]), 2))
    else $error("destination address stepped wrongly");
  chk_width_map: assert property (
    quiet_ctl |-> src_item_width == fold(ctl[6:4]) && dst_item_width == fold(ctl[3:1]))
    else $error("item width decode wrong");
  chk_hsize_src: assert property (
    quiet_ctl |-> hsize_read == fold(ctl[6:4]))
    else $error("hsize not from source width");
  chk_burst_map: assert property (
    quiet_ctl |-> src_burst_items == items(ctl[16:14]) && dst_burst_items == items(ctl[13:11]))
    else $error("burst length decode wrong");
  chk_irq_mask: assert property (
    quiet_ctl ##0 !ctl[0] |-> chan_irq == 5'h00)
    else $error("masked interrupt reached output");
  chk_irq_set: assert property (
    quiet_ctl ##0 (irq_event != 5'h00 && ctl[0]) |=>
      (chan_irq & $past(irq_event)) == $past(irq_event))
    else $error("enabled interrupt not raised");
  chk_ready_setup: assert property (
    setup_phase |=> pready)
    else $error("no ready after setup");
  chk_ready_only: assert property (
    pready |-> $past(psel && !penable))
    else $error("ready without setup");
endmodule
bind dma_channel_transfer_control dma_ctl_monitor i_mon (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .src_xfer_done, .dst_xfer_done, .irq_event, .src_addr,
  .dst_addr, .hsize_read, .src_item_width, .dst_item_width, .src_burst_items,
  .dst_burst_items, .chan_irq);

// ==== bench/far_side_model.sv ====
// Far side: memories and peripherals that finish items one at a time.
// Assumes start is a one-cycle strobe on pclk; slow leaves two idle cycles between items.
`timescale 1ns/1ns
module far_side_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic to_dst,
  input wire logic [3:0] count,
  input wire logic slow,
  output logic src_xfer_done,
  output logic dst_xfer_done,
  output logic busy
);
  logic [3:0] left;
  logic [1:0] gap;
  logic dir;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left <= 4'h0;
      gap <= 2'h0;
      dir <= 1'b0;
    end else if (start) begin
      left <= count;
      gap <= 2'h0;
      dir <= to_dst;
    end else if (left != 4'h0 && gap != 2'h0) begin
      gap <= gap - 2'h1;
    end else if (left != 4'h0) begin
      left <= left - 4'h1;
      gap <= slow ? 2'h2 : 2'h0;
    end
  end
  assign src_xfer_done = left != 4'h0 && gap == 2'h0 && !dir;
  assign dst_xfer_done = left != 4'h0 && gap == 2'h0 && dir;
  assign busy = left != 4'h0;
endmodule

// ==== bench/dma_channel_transfer_control_bench.sv ====
// Self-checking bench for the channel transfer-control block.
// Assumes the zero-wait APB slave and register map of dma_ctl_pkg.
`timescale 1ns/1ns
module dma_channel_transfer_control_bench
  import dma_ctl_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, start = 1'b0, to_dst = 1'b0, slow = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, src_addr, dst_addr, rd, want;
  logic pready, pslverr, src_xfer_done, dst_xfer_done, busy, err;
  logic [IRQ_NUM-1:0] irq_event = 5'h00, chan_irq;
  logic [2:0] hsize_read, src_item_width, dst_item_width;
  logic [8:0] src_burst_items, dst_burst_items;
  int error_cnt = 0, total_checks = 0;
  always #4 pclk = ~pclk;
  dma_channel_transfer_control i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .src_xfer_done, .dst_xfer_done, .irq_event,
    .src_addr, .dst_addr, .hsize_read, .src_item_width, .dst_item_width, .src_burst_items,
    .dst_burst_items, .chan_irq);
  far_side_model i_far (.pclk, .presetn, .start, .to_dst, .count(4'h3), .slow,
    .src_xfer_done, .dst_xfer_done, .busy);
  task automatic end_of_test();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp_v);
    total_checks++;
    if (got !== exp_v) begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp_v);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic settle();
    repeat (2) @(posedge pclk);
  endtask
  initial begin
    #200000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, OFFS_CTL_LOW, 32'h0);
    chk(rd, 32'h0000_4801);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, OFFS_CTL_LOW, 32'(i << 14 | i << 11 | i << 4 | (7 - i) << 1));
      settle();
      chk(src_item_width, (i > 5) ? 32'h5 : 32'(i));
      chk(hsize_read, (i > 5) ? 32'h5 : 32'(i));
      chk(dst_item_width, (i < 2) ? 32'h5 : 32'(7 - i));
      chk(src_burst_items, (i == 0) ? 32'h1 : 32'h2 << i);
      chk(dst_burst_items, (i == 0) ? 32'h1 : 32'h2 << i);
      apb(1'b0, OFFS_CFG_STATUS, 32'h0);
      chk(rd, {30'h0, ((7 - i) > 2), (i > 2)});
    end
    // Widths kept at 32 bits or less; hold codes model a fixed-address FIFO
    for (int s = 0; s < 4; s++) begin
      for (int w = 0; w < 3; w++) begin
        for (int d = 0; d < 2; d++) begin
          apb(1'b1, OFFS_CTL_LOW, 32'(d ? (s << 7 | w << 1) : (s << 9 | w << 4)));
          apb(1'b1, d ? OFFS_DST_START : OFFS_SRC_START, 32'h0000_1000);
          apb(1'b0, d ? OFFS_DST_START : OFFS_SRC_START, 32'h0);
          chk(rd, 32'h0000_1000);
          to_dst <= d[0];
          slow <= w[0];
          start <= 1'b1;
          @(posedge pclk);
          start <= 1'b0;
          do @(posedge pclk); while (busy);
          settle();
          want = s[1] ? 32'h1000 : s[0] ? 32'h1000 - 3 * (1 << w) : 32'h1000 + 3 * (1 << w);
          chk(d ? dst_addr : src_addr, want);
          apb(1'b0, d ? OFFS_DST_NOW : OFFS_SRC_NOW, 32'h0);
          chk(rd, want);
        end
      end
    end
    apb(1'b1, OFFS_CTL_LOW, 32'h0000_4801);
    irq_event <= 5'h1F;
    @(posedge pclk);
    irq_event <= 5'h00;
    settle();
    chk(chan_irq, 32'h1F);
    apb(1'b1, OFFS_CTL_LOW, 32'h0000_4800);
    settle();
    chk(chan_irq, 32'h0);
    apb(1'b1, OFFS_RAW_IRQ, 32'h1F);
    irq_event <= 5'h0A;
    @(posedge pclk);
    irq_event <= 5'h00;
    settle();
    chk(chan_irq, 32'h0);
    apb(1'b0, OFFS_RAW_IRQ, 32'h0);
    chk(rd, 32'h0A);
    apb(1'b1, OFFS_CTL_LOW, 32'h0000_4801);
    settle();
    chk(chan_irq, 32'h0A);
    // Event in the clearing cycle: set must win over the write-one clear
    fork
      apb(1'b1, OFFS_RAW_IRQ, 32'h1F);
      begin
        @(posedge pclk);
        irq_event <= 5'h04;
        @(posedge pclk);
        irq_event <= 5'h00;
      end
    join
    apb(1'b0, OFFS_RAW_IRQ, 32'h0);
    chk(rd, 32'h04);
    chk(chan_irq, 32'h04);
    apb(1'b0, 12'h0FC, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    end_of_test();
  end
endmodule
